/* File: common/kwu_pkg.sv */
// Purpose: Shared constants for the keypad wake interrupt unit
// Assumes: 8-bit register data, 4-bit register index
// Notes: Offsets and bit positions are fixed here once
package kwu_pkg;
  localparam int unsigned KWU_PINS = 8;
  localparam int unsigned KWU_AW = 4;
  localparam int unsigned KWU_DW = 8;
  localparam int unsigned KWU_SYNC_STAGES = 2;

  localparam logic [3:0] KWU_ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] KWU_ADDR_ENABLE = 4'h1;

  localparam int unsigned KWU_BIT_TRIGGER_SEL = 0;
  localparam int unsigned KWU_BIT_REQUEST_MASK = 1;
  localparam int unsigned KWU_BIT_ACK = 2;
  localparam int unsigned KWU_BIT_PENDING = 3;

  localparam logic KWU_RST_TRIGGER_SEL = 1'b0;
  localparam logic KWU_RST_REQUEST_MASK = 1'b0;
  localparam logic KWU_RST_PENDING = 1'b0;
  localparam logic [7:0] KWU_RST_ENABLES = 8'h00;

  localparam logic [15:0] KWU_VECTOR_ADDR = 16'hFFE0;
endpackage : kwu_pkg

/* File: core/kwu_sync.sv */
// Purpose: Two-flop synchroniser for the keypad pins
// Assumes: Pins idle high through pull-ups
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module kwu_sync
  import kwu_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [KWU_PINS-1:0] pins_i,
  output logic [KWU_PINS-1:0] pins_o
);
  logic [KWU_PINS-1:0] meta_q;
  logic [KWU_PINS-1:0] sync_q;

  genvar g;
  generate
    for (g = 0; g < KWU_PINS; g++) begin : g_bit
      // Reset to high so no false fall appears at release
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
        end else begin
          meta_q[g] <= pins_i[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign pins_o = sync_q;
endmodule // kwu_sync
`default_nettype wire

/* File: core/kwu_detect.sv */
// Purpose: Enabled-low and first-fall detection across all keypad pins
// Assumes: Synchronised pin levels
// Notes: A fall counts only when every enabled pin was high before
`timescale 1ns/1ns
`default_nettype none
module kwu_detect
  import kwu_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [KWU_PINS-1:0] pins_i,
  input wire logic [KWU_PINS-1:0] enables_i,
  output logic any_low_o,
  output logic fall_o
);
  logic prev_any_low_q;
  wire [KWU_PINS-1:0] low_enabled = ~pins_i & enables_i;
  wire any_low = |low_enabled;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_any_low_q <= 1'b0;
    end else begin
      prev_any_low_q <= any_low;
    end
  end

  assign any_low_o = any_low;
  // Another pin already low hides a new fall
  assign fall_o = any_low & ~prev_any_low_q; // [R3] [R4]
endmodule // kwu_detect
`default_nettype wire

/* File: core/kwu_unit.sv */
// Purpose: Keypad wake interrupt unit, eight pins, one shared request
// Assumes: Plain register port, read data one cycle after the strobe
// Notes: Request also drives the wake line in wait and stop
//
// Overview of operation
// [R1] Eight pin inputs, each enabled separately, one mask, one pending request.
// [R2] An enabled pin also gets its internal pull-up switched on.
// [R3] Request latches when an enabled pin falls after all enabled were high.
// [R4] Edge mode: a fall is ignored while another enabled pin stays low.
// [R5] Level mode: request holds while any enabled pin is low.
// [R6] Level mode: clears only after acknowledge and all enabled pins high.
// [R7] Acknowledge comes from vector fetch or writing one to the ack bit.
// [R8] A fall after an acknowledge latches a fresh request.
// [R9] Unmasked pending request goes to the CPU, vector at FFE0/FFE1.
// [R10] Edge mode: acknowledge clears the request at once, any pin levels.
// [R11] Reset clears request and trigger select, even with a pin low.
// [R12] Pending flag shows the latch regardless of the mask.
// [R13] An enabled pin is forced to input, overriding its direction bit.
// [R14] Unit runs in wait and stop; unmasked request wakes the part.
// [R15] In break, ack writes work only with break-clear enable set.
// [R16] Upper four status bits read as zero.
// [R17] Pending flag set while a request is pending, cleared by reset.
// [R18] Software masks, enables pins, acknowledges, then unmasks at start-up.
// [R19] Software may instead drive pins high as outputs before enabling.
// [R20] Ack bit is write-only and always reads as zero.
// [R21] Mask bit is read/write, reset clear, one blocks requests.
// [R22] Trigger select is read/write, reset clear, one adds low levels.
// [R23] Eight read/write pin enables, all cleared by reset.
// [R24] Pins synchronised before detection; ack acts at the write's end.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module kwu_unit
  import kwu_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [KWU_AW-1:0] reg_addr_i,
  input wire logic [KWU_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [KWU_DW-1:0] reg_rdata_o,
  input wire logic [KWU_PINS-1:0] port_a_pins_i,
  input wire logic [KWU_PINS-1:0] port_a_direction_i,
  output logic [KWU_PINS-1:0] port_a_oe_o,
  output logic [KWU_PINS-1:0] pullup_en_o,
  input wire logic vector_fetch_i,
  input wire logic break_state_i,
  input wire logic break_clear_enable_i,
  output logic irq_o,
  output logic wake_o,
  output logic [15:0] vector_addr_o
);
  logic [KWU_PINS-1:0] keypad_pin_enables_q;
  logic keypad_request_mask_q;
  logic keypad_trigger_sel_q;
  logic keypad_pending_flag_q;
  logic keypad_pending_flag_d;
  logic ack_seen_q;
  logic ack_seen_d;
  logic [KWU_DW-1:0] rdata_q;
  logic [KWU_DW-1:0] rdata_d;
  logic [KWU_PINS-1:0] pins_sync;
  logic any_low;
  logic fall_event;

  kwu_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pins_i(port_a_pins_i),
    .pins_o(pins_sync)
  ); // [R24]

  kwu_detect u_detect (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pins_i(pins_sync),
    .enables_i(keypad_pin_enables_q),
    .any_low_o(any_low),
    .fall_o(fall_event)
  ); // [R1] [R3] [R4]

  // Register decode
  wire sel_sc = (reg_addr_i == KWU_ADDR_STATUS_CONTROL);
  wire sel_en = (reg_addr_i == KWU_ADDR_ENABLE);
  wire wr_sc = reg_we_i & sel_sc;
  wire wr_en = reg_we_i & sel_en;
  wire ack_write = wr_sc & reg_wdata_i[KWU_BIT_ACK];
  // Break blocks ack writes unless clearing is allowed; vector fetch still acks
  wire ack_allowed = ~break_state_i | break_clear_enable_i; // [R15]
  wire keypad_ack = vector_fetch_i | (ack_write & ack_allowed); // [R7]

  // Level mode keeps the request while a pin is low
  wire set_req = fall_event | (keypad_trigger_sel_q & any_low); // [R3] [R5] [R8]
  wire clr_level = (keypad_ack | ack_seen_q) & ~any_low; // [R6]
  wire clr_req = keypad_trigger_sel_q ? clr_level : keypad_ack; // [R6] [R10]

  // Set wins over clear so no fall is lost
  assign keypad_pending_flag_d = set_req | (keypad_pending_flag_q & ~clr_req); // [R8] [R17]
  // Remember an early ack until the pins return high
  assign ack_seen_d = keypad_trigger_sel_q & keypad_pending_flag_q & any_low & (keypad_ack | ack_seen_q); // [R6]

  wire [KWU_DW-1:0] sc_read = {4'h0, keypad_pending_flag_q, 1'b0, keypad_request_mask_q,
                               keypad_trigger_sel_q}; // [R12] [R16] [R20]
  wire [KWU_DW-1:0] rd_mux = sel_sc ? sc_read : (sel_en ? keypad_pin_enables_q : 8'h00);
  assign rdata_d = reg_re_i ? rd_mux : 8'h00;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      keypad_request_mask_q <= KWU_RST_REQUEST_MASK; // [R21]
      keypad_trigger_sel_q <= KWU_RST_TRIGGER_SEL; // [R11] [R22]
    end else if (wr_sc) begin
      keypad_request_mask_q <= reg_wdata_i[KWU_BIT_REQUEST_MASK]; // [R21]
      keypad_trigger_sel_q <= reg_wdata_i[KWU_BIT_TRIGGER_SEL]; // [R22]
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      keypad_pin_enables_q <= KWU_RST_ENABLES; // [R23]
    end else if (wr_en) begin
      keypad_pin_enables_q <= reg_wdata_i; // [R23]
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      keypad_pending_flag_q <= KWU_RST_PENDING; // [R11] [R17]
      ack_seen_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      keypad_pending_flag_q <= keypad_pending_flag_d;
      ack_seen_q <= ack_seen_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign pullup_en_o = keypad_pin_enables_q; // [R2]
  // Enable overrides direction; pin reads remain the port's job
  assign port_a_oe_o = port_a_direction_i & ~keypad_pin_enables_q; // [R13]
  assign irq_o = keypad_pending_flag_q & ~keypad_request_mask_q; // [R9] [R21]
  // No clock gating here, so wake follows the request directly
  assign wake_o = irq_o; // [R14]
  assign vector_addr_o = KWU_VECTOR_ADDR; // [R9]

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_upper_zero;
    (reg_re_i && sel_sc) |=> (reg_rdata_o[7:4] == 4'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("status upper bits not zero"); // [R16]

  property p_ack_reads_zero;
    (reg_re_i && sel_sc) |=> (reg_rdata_o[KWU_BIT_ACK] == 1'b0);
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read as one"); // [R20]

  property p_pending_visible;
    (reg_re_i && sel_sc) |=> (reg_rdata_o[KWU_BIT_PENDING] == $past(keypad_pending_flag_q));
  endproperty
  a_pending_visible: assert property (p_pending_visible) else $error("pending flag not shown"); // [R12]

  property p_enable_pullup;
    wr_en |=> (pullup_en_o == $past(reg_wdata_i));
  endproperty
  a_enable_pullup: assert property (p_enable_pullup) else $error("pull-up not following enable"); // [R2]

  property p_enabled_input;
    (port_a_oe_o & pullup_en_o) == 8'h00;
  endproperty
  a_enabled_input: assert property (p_enabled_input) else $error("enabled pin driven"); // [R13]

  property p_fall_sets;
    fall_event |=> keypad_pending_flag_q;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall did not latch request"); // [R3]

  property p_no_fall_while_low;
    $past(any_low) |-> !fall_event;
  endproperty
  a_no_fall_while_low: assert property (p_no_fall_while_low) else $error("fall seen while pin low"); // [R4]

  property p_edge_ack_clears;
    (!keypad_trigger_sel_q && vector_fetch_i && !fall_event) |=> !keypad_pending_flag_q;
  endproperty
  a_edge_ack_clears: assert property (p_edge_ack_clears) else $error("edge mode ack did not clear"); // [R10]

  property p_level_holds;
    (keypad_trigger_sel_q && any_low) |=> keypad_pending_flag_q;
  endproperty
  a_level_holds: assert property (p_level_holds) else $error("level request dropped while low"); // [R5]

  property p_break_blocks;
    (ack_write && break_state_i && !break_clear_enable_i && !vector_fetch_i && !set_req && !ack_seen_q)
      |=> (keypad_pending_flag_q == $past(keypad_pending_flag_q));
  endproperty
  a_break_blocks: assert property (p_break_blocks) else $error("ack acted during break"); // [R15]

  property p_mask_blocks;
    keypad_request_mask_q |-> (!irq_o && !wake_o);
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked request reached cpu"); // [R21]

  property p_sw_ack_clears;
    (!keypad_trigger_sel_q && ack_write && !break_state_i && !fall_event) |=> !keypad_pending_flag_q;
  endproperty
  a_sw_ack_clears: assert property (p_sw_ack_clears) else $error("ack write did not clear"); // [R7] [R10]

  property p_edge_holds;
    (!keypad_trigger_sel_q && keypad_pending_flag_q && !keypad_ack) |=> keypad_pending_flag_q;
  endproperty
  a_edge_holds: assert property (p_edge_holds) else $error("edge request dropped without ack"); // [R10]

  property p_level_needs_ack;
    (keypad_trigger_sel_q && keypad_pending_flag_q && !keypad_ack && !ack_seen_q) |=> keypad_pending_flag_q;
  endproperty
  a_level_needs_ack: assert property (p_level_needs_ack) else $error("level request dropped without ack"); // [R6]

  property p_level_both_clear;
    (keypad_trigger_sel_q && keypad_pending_flag_q && ack_seen_q && !any_low) |=> !keypad_pending_flag_q;
  endproperty
  a_level_both_clear: assert property (p_level_both_clear) else $error("level request stuck after ack"); // [R6]

  property p_ack_seen_needs_low;
    ack_seen_q |-> $past(any_low);
  endproperty
  a_ack_seen_needs_low: assert property (p_ack_seen_needs_low) else $error("ack held with pins high"); // [R6]

  property p_ack_seen_level_only;
    $past(!keypad_trigger_sel_q) |-> !ack_seen_q;
  endproperty
  a_ack_seen_level_only: assert property (p_ack_seen_level_only) else $error("ack held in edge mode"); // [R6]

  property p_fresh_after_ack;
    (keypad_ack && fall_event) |=> keypad_pending_flag_q;
  endproperty
  a_fresh_after_ack: assert property (p_fresh_after_ack) else $error("fall lost to ack"); // [R8]

  property p_break_clear_allowed;
    (ack_write && break_state_i && break_clear_enable_i && !keypad_trigger_sel_q && !fall_event)
      |=> !keypad_pending_flag_q;
  endproperty
  a_break_clear_allowed: assert property (p_break_clear_allowed) else $error("allowed break ack ignored"); // [R15]

  property p_masked_still_pends;
    (fall_event && keypad_request_mask_q) |=> keypad_pending_flag_q;
  endproperty
  a_masked_still_pends: assert property (p_masked_still_pends) else $error("masked fall not latched"); // [R12]

  property p_unmasked_request;
    (keypad_pending_flag_q && !keypad_request_mask_q) |-> irq_o;
  endproperty
  a_unmasked_request: assert property (p_unmasked_request) else $error("unmasked request not raised"); // [R9]

  property p_wake_follows;
    wake_o == irq_o;
  endproperty
  a_wake_follows: assert property (p_wake_follows) else $error("wake differs from request"); // [R14]

  property p_vector_fixed;
    vector_addr_o == KWU_VECTOR_ADDR;
  endproperty
  a_vector_fixed: assert property (p_vector_fixed) else $error("vector address wrong"); // [R9]

  property p_mask_write;
    wr_sc |=> (keypad_request_mask_q == $past(reg_wdata_i[KWU_BIT_REQUEST_MASK]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // [R21]

  property p_trigger_write;
    wr_sc |=> (keypad_trigger_sel_q == $past(reg_wdata_i[KWU_BIT_TRIGGER_SEL]));
  endproperty
  a_trigger_write: assert property (p_trigger_write) else $error("trigger select write lost"); // [R22]

  property p_enables_read;
    (reg_re_i && sel_en) |=> (reg_rdata_o == $past(keypad_pin_enables_q));
  endproperty
  a_enables_read: assert property (p_enables_read) else $error("enable read back wrong"); // [R23]

  property p_rdata_idle;
    !reg_re_i |=> (reg_rdata_o == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle"); // [R16]

  property p_disabled_quiet;
    (keypad_pin_enables_q == 8'h00) |-> !any_low;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled pin seen low"); // [R1]

  property p_oe_follows_dir;
    (pullup_en_o == 8'h00) |-> (port_a_oe_o == port_a_direction_i);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("drive not following direction"); // [R13]

  property p_no_spontaneous;
    (!set_req && !keypad_pending_flag_q) |=> !keypad_pending_flag_q;
  endproperty
  a_no_spontaneous: assert property (p_no_spontaneous) else $error("request set with no cause"); // [R3] [R17]

  c_edge_request: cover property (fall_event ##1 irq_o);
  c_fresh_request: cover property (keypad_ack ##[1:40] fall_event);
  c_break_blocked: cover property (ack_write && break_state_i && !break_clear_enable_i && keypad_pending_flag_q);
  c_level_clear: cover property (keypad_trigger_sel_q && keypad_ack && any_low ##[1:50] !keypad_pending_flag_q);
  c_break_clear: cover property (ack_write && break_state_i && break_clear_enable_i && keypad_pending_flag_q);
endmodule // kwu_unit
`default_nettype wire

/* File: testbench/kwu_keypad_model.sv */
// Purpose: Keypad switch model on the port pins
// Assumes: A pressed key pulls its pin to 0
// Notes: An unpulled open pin toggles each cycle, never a steady level
`timescale 1ns/1ns
`default_nettype none
module kwu_keypad_model
  import kwu_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [KWU_PINS-1:0] keys_i,
  input wire logic [KWU_PINS-1:0] pullup_en_i,
  output logic [KWU_PINS-1:0] pins_o
);
  logic [KWU_PINS-1:0] float_q = 8'h55;
  always @(posedge core_clk_i) begin
    float_q <= ~float_q;
  end
  assign pins_o = ~keys_i & (pullup_en_i | float_q);
endmodule // kwu_keypad_model
`default_nettype wire

/* File: testbench/kwu_unit_tb.sv */
// Purpose: Self-checking bench for the keypad wake unit
// Assumes: Read data stands one cycle after the read strobe
// Notes: Keys reach the pins through the switch model
`timescale 1ns/1ns
`default_nettype none
module kwu_unit_tb;
  import kwu_pkg::*;
  logic clk, rst, we, re, vf, brk, brk_clr, irq, wake;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, keys, dir, oe, pu, pins;
  logic [15:0] vaddr;
  int fails = 0;
  int n_compared = 0;
  kwu_unit dut_u (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we),
    .reg_re_i(re), .reg_rdata_o(rdata), .port_a_pins_i(pins), .port_a_direction_i(dir), .port_a_oe_o(oe),
    .pullup_en_o(pu), .vector_fetch_i(vf), .break_state_i(brk), .break_clear_enable_i(brk_clr),
    .irq_o(irq), .wake_o(wake), .vector_addr_o(vaddr));
  kwu_keypad_model keys_u (.core_clk_i(clk), .keys_i(keys), .pullup_en_i(pu), .pins_o(pins));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(nm, {8'h00, rdata}, {8'h00, exp});
  endtask
  // Status read plus the request lines that follow from it
  task automatic st(input logic p, input logic m, input logic md);
    logic [7:0] e;
    e = 8'h00;
    e[KWU_BIT_PENDING] = p;
    e[KWU_BIT_REQUEST_MASK] = m;
    e[KWU_BIT_TRIGGER_SEL] = md;
    rd(KWU_ADDR_STATUS_CONTROL, e, "status");
    chk("irq", {15'h0000, irq}, {15'h0000, p & ~m});
    chk("wake", {15'h0000, wake}, {15'h0000, p & ~m});
  endtask
  // Two sync cycles and the latch cycle plus margin before looking
  task automatic press(input logic [7:0] k);
    @(posedge clk);
    keys <= k;
    repeat (5) @(posedge clk);
  endtask
  task automatic fetch;
    @(posedge clk);
    vf <= 1'b1;
    @(posedge clk);
    vf <= 1'b0;
  endtask
  task automatic t_reset;
    st(1'b0, 1'b0, 1'b0);
    rd(KWU_ADDR_ENABLE, 8'h00, "enables");
    chk("pullups", {8'h00, pu}, 16'h0000);
    wr(KWU_ADDR_STATUS_CONTROL, 8'hF8);
    st(1'b0, 1'b0, 1'b0);
    rd(4'hF, 8'h00, "unmapped");
  endtask
  // Pins held as outputs first, then the masked start-up order
  task automatic t_init;
    @(posedge clk);
    dir <= 8'hFF;
    wr(KWU_ADDR_STATUS_CONTROL, 8'h02);
    wr(KWU_ADDR_ENABLE, 8'h03);
    repeat (3) @(posedge clk);
    wr(KWU_ADDR_STATUS_CONTROL, 8'h06);
    st(1'b0, 1'b1, 1'b0);
    wr(KWU_ADDR_STATUS_CONTROL, 8'h00);
    rd(KWU_ADDR_ENABLE, 8'h03, "enables");
    chk("pullups", {8'h00, pu}, 16'h0003);
    chk("oe", {8'h00, oe}, 16'h00FC);
  endtask
  task automatic t_edge;
    press(8'h01);
    st(1'b1, 1'b0, 1'b0);
    chk("vector", vaddr, 16'hFFE0);
    wr(KWU_ADDR_STATUS_CONTROL, 8'h04);
    st(1'b0, 1'b0, 1'b0);
    press(8'h03);
    st(1'b0, 1'b0, 1'b0);
    press(8'h00);
    press(8'h02);
    st(1'b1, 1'b0, 1'b0);
    wr(KWU_ADDR_STATUS_CONTROL, 8'h04);
    press(8'h00);
  endtask
  task automatic t_mask;
    wr(KWU_ADDR_STATUS_CONTROL, 8'h02);
    press(8'h01);
    st(1'b1, 1'b1, 1'b0);
    wr(KWU_ADDR_STATUS_CONTROL, 8'h06);
    press(8'h00);
    wr(KWU_ADDR_STATUS_CONTROL, 8'h00);
  endtask
  task automatic t_level;
    wr(KWU_ADDR_STATUS_CONTROL, 8'h01);
    press(8'h01);
    fetch();
    st(1'b1, 1'b0, 1'b1);
    press(8'h00);
    st(1'b0, 1'b0, 1'b1);
    press(8'h02);
    press(8'h00);
    st(1'b1, 1'b0, 1'b1);
    fetch();
    st(1'b0, 1'b0, 1'b1);
  endtask
  task automatic t_break;
    wr(KWU_ADDR_STATUS_CONTROL, 8'h00);
    press(8'h01);
    brk <= 1'b1;
    wr(KWU_ADDR_STATUS_CONTROL, 8'h04);
    st(1'b1, 1'b0, 1'b0);
    brk_clr <= 1'b1;
    wr(KWU_ADDR_STATUS_CONTROL, 8'h04);
    brk <= 1'b0;
    brk_clr <= 1'b0;
    st(1'b0, 1'b0, 1'b0);
    press(8'h00);
  endtask
  // Reset with a key still held low
  task automatic t_rst_low;
    wr(KWU_ADDR_STATUS_CONTROL, 8'h01);
    press(8'h01);
    st(1'b1, 1'b0, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    st(1'b0, 1'b0, 1'b0);
    rd(KWU_ADDR_ENABLE, 8'h00, "enables");
  endtask
  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {we, re, vf, brk, brk_clr} = 5'h00;
    {addr, wdata, keys, dir} = 28'h000_0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_init();
    t_edge();
    t_mask();
    t_level();
    t_break();
    t_rst_low();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
endmodule // kwu_unit_tb
`default_nettype wire
